// >>> iatm_pkg.sv
// iatm_pkg: constants, register map and types of the interrupt auto-mask / throttle / map block
package iatm_pkg;
    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int          IATM_ADDR_W        = 16;
    localparam logic [15:0] IATM_CAUSE_OFF     = 16'h1500;
    localparam logic [15:0] IATM_MASK_SET_OFF  = 16'h1508;
    localparam logic [15:0] IATM_MASK_CLR_OFF  = 16'h150C;
    localparam logic [15:0] IATM_AUTO_MASK_OFF = 16'h1510;
    localparam logic [15:0] IATM_CONTROL_OFF   = 16'h1514;
    localparam logic [15:0] IATM_THR_BASE_OFF  = 16'h1680;
    localparam logic [15:0] IATM_ALLOC_BASE_OFF = 16'h1700;
    localparam logic [31:0] IATM_ZERO_WORD     = 32'h0000_0000;
    // ------------------------------------------------------------------
    // counts of units
    // ------------------------------------------------------------------
    localparam int IATM_NUM_THR     = 5;
    localparam int IATM_NUM_ALLOC   = 2;
    localparam int IATM_FLD_PER_REG = 4;
    localparam int IATM_NUM_QUEUE   = 8;
    localparam int IATM_FLD_STRIDE  = 8;
    localparam int IATM_TGT_W       = 3;
    localparam int IATM_VALID_POS   = 7;
    localparam logic [2:0] IATM_MSIX_TARGETS   = 3'h5;
    localparam logic [2:0] IATM_LEGACY_TARGETS = 3'h4;
    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int IATM_AUTO_MASK_W   = 31;
    localparam int IATM_KEEP_POS      = 30;
    localparam int IATM_TRUE_INTERRUPT_FLAG_POS      = 31;
    localparam int IATM_DRSTA_POS     = 30;
    localparam int IATM_NSICR_POS     = 0;
    localparam int IATM_MSIX_POS      = 4;
    localparam int IATM_LLI_IVL_LSB   = 7;
    localparam int IATM_LLI_IVL_W     = 5;
    localparam int IATM_INTERVAL_LSB  = 2;
    localparam int IATM_INTERVAL_W    = 13;
    localparam int IATM_LOW_LATENCY_MODERATION_ENABLE_POS    = 15;
    localparam int IATM_CREDIT_LSB    = 16;
    localparam int IATM_CREDIT_W      = 5;
    localparam int IATM_MODCNT_LSB    = 21;
    localparam int IATM_MODCNT_W      = 10;
    localparam int IATM_PRESERVE_POS  = 31;
    localparam int IATM_COUNT_W       = 12;
    localparam int IATM_COUNT_DROP    = 2;
    localparam logic [IATM_COUNT_W-1:0]  IATM_COUNT_MAX  = 12'hFFF;
    localparam logic [IATM_CREDIT_W-1:0] IATM_CREDIT_MAX = 5'h1F;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int IATM_CLK_PERIOD_NS = 4;
    localparam int IATM_TICK_NS       = 1000;
    localparam int IATM_TICK_CYCLES   = (IATM_TICK_NS + IATM_CLK_PERIOD_NS - 1) / IATM_CLK_PERIOD_NS;
    localparam int IATM_PRE_W         = 8;
    localparam logic [IATM_PRE_W-1:0] IATM_PRE_LAST = IATM_PRE_W'(IATM_TICK_CYCLES - 1);
    localparam int IATM_LL_W          = 7;
    localparam logic [1:0] IATM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] IATM_RESP_DECERR = 2'h3;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [IATM_INTERVAL_W-1:0] interval;
        logic                       low_latency_moderation_enable;
        logic [IATM_CREDIT_W-1:0]   credit;
        logic [IATM_COUNT_W-1:0]    count;
    } iatm_thr_t;
    typedef struct packed {
        logic [IATM_ADDR_W-1:0] addr;
        logic [31:0]            data;
        logic [3:0]             strb;
    } iatm_wreq_t;
endpackage : iatm_pkg

// >>> iatm_top.sv
// iatm_top: auto-mask, five interrupt throttles and queue cause allocation behind AXI4-Lite
// How it works
// - cause register read or write clears mask bits selected by auto-mask
// - with nonselective clear off, copy needs nonzero mask and true interrupt flag
// - software device reset clears auto-mask except bit 30
// - five throttle registers at four byte stride, one per cause group
// - interval field bits 14:2 in microseconds; software never writes zero
// - interrupt sent after interval microsecond ticks, at most 4095, unless flushed or low latency
// - 12-bit down counter, top 10 bits visible, reloads on signal, stops at zero
// - signal when counter zero and an allocated extended cause bit set
// - write without preserve bit loads moderation and credit counters
// - preserve bit 31 keeps both counters for that write, reads zero
// - bit 15 enables low latency moderation, bits 20:16 show credits
// - device reset leaves throttles alone; reset interrupt flushes pending at once
// - two allocation registers map queue causes to vectors in vector mode
// - outside vector mode same fields route causes to extended cause bits
// - four 3-bit targets at bytes with valid bit 7 of each byte
// - irq_out presented only when cause bit and mask bit both one
// - mask clear write of one clears mask bit, zero leaves it
// - nonselective clear on: every cause read clears cause register
`timescale 1ns/1ns
`default_nettype none
module iatm_top
    import iatm_pkg::*;
(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [IATM_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [IATM_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic [30:0]              cause_event,
    input  wire logic [IATM_NUM_QUEUE-1:0] queue_cause_bits,
    input  wire logic [IATM_NUM_THR-1:0]  low_latency_event,
    input  wire logic                     software_device_reset,
    input  wire logic                     device_reset_event,
    output logic                          irq_out,
    output logic [IATM_NUM_THR-1:0]       vector_irq,
    output logic [IATM_NUM_THR-1:0]       extended_cause_reg
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    iatm_wreq_t                  wreq_reg;
    logic                        aw_held_reg;
    logic                        w_held_reg;
    logic                        bvalid_reg;
    logic [1:0]                  bresp_reg;
    logic                        rvalid_reg;
    logic [1:0]                  rresp_reg;
    logic [31:0]                 rdata_reg;
    logic [30:0]                 cause_reg;
    logic [30:0]                 mask_reg;
    logic [IATM_AUTO_MASK_W-1:0] auto_mask_value;
    logic [31:0]                 control_reg;
    logic [31:0]                 alloc_reg [IATM_NUM_ALLOC];
    iatm_thr_t                   thr_reg [IATM_NUM_THR];
    logic [IATM_NUM_THR-1:0]     ext_reg;
    logic [IATM_NUM_THR-1:0]     vec_reg;
    logic                        irq_reg;
    logic [IATM_PRE_W-1:0]       pre_reg;
    logic                        tick_reg;
    logic [IATM_LL_W-1:0]        ll_reg;
    logic                        ll_tick_reg;

    // ------------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------------
    logic wr_fire;
    logic rd_fire;
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign irq_out            = irq_reg;
    assign vector_irq         = vec_reg;
    assign extended_cause_reg = ext_reg;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic thr_hit(input logic [IATM_ADDR_W-1:0] a);
        return (a[IATM_ADDR_W-1:5] == IATM_THR_BASE_OFF[IATM_ADDR_W-1:5]) &&
               (a[4:2] < 3'(IATM_NUM_THR)) && (a[1:0] == 2'h0);
    endfunction : thr_hit

    function automatic logic alloc_hit(input logic [IATM_ADDR_W-1:0] a);
        return (a[IATM_ADDR_W-1:3] == IATM_ALLOC_BASE_OFF[IATM_ADDR_W-1:3]) &&
               (a[1:0] == 2'h0);
    endfunction : alloc_hit

    function automatic logic known(input logic [IATM_ADDR_W-1:0] a);
        return (a == IATM_CAUSE_OFF) || (a == IATM_MASK_SET_OFF) || (a == IATM_MASK_CLR_OFF) ||
               (a == IATM_AUTO_MASK_OFF) || (a == IATM_CONTROL_OFF) || thr_hit(a) || alloc_hit(a);
    endfunction : known

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            wreq_reg    <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= IATM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg   <= 1'b1;
                wreq_reg.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg    <= 1'b1;
                wreq_reg.data <= s_axi_wdata;
                wreq_reg.strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= known(wreq_reg.addr) ? IATM_RESP_OKAY : IATM_RESP_DECERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // decoded accesses
    // ------------------------------------------------------------------
    logic [31:0] wdat;
    logic        true_interrupt_flag;
    logic        cause_rd;
    logic        cause_wr;
    logic        auto_apply;
    logic        cause_rd_clear;
    assign wdat     = wreq_reg.data;
    assign true_interrupt_flag     = |(cause_reg & mask_reg);
    assign cause_rd = rd_fire && (s_axi_araddr == IATM_CAUSE_OFF);
    assign cause_wr = wr_fire && (wreq_reg.addr == IATM_CAUSE_OFF);
    assign auto_apply = (cause_rd || cause_wr) &&
                        (control_reg[IATM_NSICR_POS] || ((|mask_reg) && true_interrupt_flag));
    assign cause_rd_clear = cause_rd &&
                            (control_reg[IATM_NSICR_POS] || true_interrupt_flag || !(|mask_reg));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= IATM_RESP_OKAY;
            rdata_reg  <= IATM_ZERO_WORD;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= known(s_axi_araddr) ? IATM_RESP_OKAY : IATM_RESP_DECERR;
            rdata_reg  <= IATM_ZERO_WORD;
            if (s_axi_araddr == IATM_CAUSE_OFF) begin
                rdata_reg <= {true_interrupt_flag, cause_reg};
            end else if (s_axi_araddr == IATM_MASK_SET_OFF || s_axi_araddr == IATM_MASK_CLR_OFF) begin
                rdata_reg <= {1'b0, mask_reg};
            end else if (s_axi_araddr == IATM_AUTO_MASK_OFF) begin
                rdata_reg <= {1'b0, auto_mask_value};
            end else if (s_axi_araddr == IATM_CONTROL_OFF) begin
                rdata_reg <= control_reg;
            end else if (thr_hit(s_axi_araddr)) begin
                rdata_reg <= {1'b0,
                    thr_reg[s_axi_araddr[4:2]].count[IATM_COUNT_W-1:IATM_COUNT_DROP],
                    thr_reg[s_axi_araddr[4:2]].credit, thr_reg[s_axi_araddr[4:2]].low_latency_moderation_enable,
                    thr_reg[s_axi_araddr[4:2]].interval, 2'h0};
            end else if (alloc_hit(s_axi_araddr)) begin
                rdata_reg <= alloc_reg[s_axi_araddr[2]];
            end
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // cause, mask, auto-mask and control
    // ------------------------------------------------------------------
    logic [30:0] cause_set;
    assign cause_set = cause_event | (31'(device_reset_event) << IATM_DRSTA_POS);

    // strobed write word, taken apart below since a call result cannot be sliced
    logic [31:0] wmerged;
    logic [31:0] am_merged;
    assign wmerged   = merge(IATM_ZERO_WORD, wdat, wreq_reg.strb);
    assign am_merged = merge({1'b0, auto_mask_value}, wdat, wreq_reg.strb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause_reg <= '0;
        end else begin
            // a new event wins over the clear in the same cycle
            cause_reg <= (cause_reg & ~(cause_rd_clear ? ~31'h0 : (cause_wr ? wdat[30:0] : 31'h0)))
                         | cause_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg <= '0;
        end else if (wr_fire && wreq_reg.addr == IATM_MASK_SET_OFF) begin
            mask_reg <= mask_reg | wmerged[30:0];
        end else if (wr_fire && wreq_reg.addr == IATM_MASK_CLR_OFF) begin
            mask_reg <= mask_reg & ~wmerged[30:0];
        end else if (auto_apply) begin
            mask_reg <= mask_reg & ~auto_mask_value;
        end
    end

    always_ff @(posedge aclk) begin
        irq_reg <= aresetn && true_interrupt_flag;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_mask_value <= '0;
        end else if (software_device_reset) begin
            auto_mask_value <= auto_mask_value & (31'h1 << IATM_KEEP_POS);
        end else if (wr_fire && wreq_reg.addr == IATM_AUTO_MASK_OFF) begin
            auto_mask_value <= am_merged[30:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_reg <= IATM_ZERO_WORD;
        end else if (wr_fire && wreq_reg.addr == IATM_CONTROL_OFF) begin
            control_reg <= merge(control_reg, wdat, wreq_reg.strb) &
                           ((32'h1 << IATM_NSICR_POS) | (32'h1 << IATM_MSIX_POS) |
                            (32'h1F << IATM_LLI_IVL_LSB));
        end
    end

    // ------------------------------------------------------------------
    // allocation and extended cause bits
    // ------------------------------------------------------------------
    logic [31:0] alloc_keep;
    assign alloc_keep = 32'h8787_8787;

    for (genvar r = 0; r < IATM_NUM_ALLOC; r++) begin : g_alloc
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                alloc_reg[r] <= IATM_ZERO_WORD;
            end else if (wr_fire && alloc_hit(wreq_reg.addr) && wreq_reg.addr[2] == 1'(r)) begin
                alloc_reg[r] <= merge(alloc_reg[r], wdat, wreq_reg.strb) & alloc_keep;
            end
        end
    end

    logic [IATM_NUM_THR-1:0] route_set;
    logic [IATM_NUM_THR-1:0] fire;
    always_comb begin
        logic [7:0]            fld;
        logic [IATM_TGT_W-1:0] tgt;
        fld = 8'h00;
        tgt = '0;
        route_set = '0;
        for (int q = 0; q < IATM_NUM_QUEUE; q++) begin
            fld = alloc_reg[q / IATM_FLD_PER_REG][(q % IATM_FLD_PER_REG)*IATM_FLD_STRIDE +: 8];
            tgt = fld[IATM_TGT_W-1:0];
            // targets beyond the mode's range are dropped rather than aliased
            if (queue_cause_bits[q] && fld[IATM_VALID_POS] &&
                tgt < (control_reg[IATM_MSIX_POS] ? IATM_MSIX_TARGETS : IATM_LEGACY_TARGETS)) begin
                route_set[tgt] = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_reg <= '0;
            vec_reg <= '0;
        end else begin
            ext_reg <= (ext_reg & ~fire) | route_set;
            vec_reg <= fire;
        end
    end

    // ------------------------------------------------------------------
    // microsecond prescaler and low latency credit clock
    // ------------------------------------------------------------------
    logic [IATM_LL_W-1:0] ll_limit;
    assign ll_limit = {control_reg[IATM_LLI_IVL_LSB +: IATM_LLI_IVL_W], 2'h0};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (pre_reg == IATM_PRE_LAST);
            pre_reg  <= (pre_reg == IATM_PRE_LAST) ? '0 : pre_reg + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ll_reg      <= '0;
            ll_tick_reg <= 1'b0;
        end else begin
            ll_tick_reg <= 1'b0;
            if (ll_limit == '0) begin
                ll_reg <= '0;
            end else if (tick_reg) begin
                ll_tick_reg <= (ll_reg + 1'b1 >= ll_limit);
                ll_reg      <= (ll_reg + 1'b1 >= ll_limit) ? '0 : ll_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // throttle units
    // ------------------------------------------------------------------
    for (genvar n = 0; n < IATM_NUM_THR; n++) begin : g_thr
        logic        thr_wr;
        logic        lli_fire;
        logic [31:0] m;
        assign m = merge({1'b0, thr_reg[n].count[IATM_COUNT_W-1:IATM_COUNT_DROP], thr_reg[n].credit,
                          thr_reg[n].low_latency_moderation_enable, thr_reg[n].interval, 2'h0}, wdat, wreq_reg.strb);
        assign thr_wr   = wr_fire && thr_hit(wreq_reg.addr) && wreq_reg.addr[4:2] == 3'(n);
        assign lli_fire = thr_reg[n].low_latency_moderation_enable && (thr_reg[n].credit != '0) && low_latency_event[n];
        assign fire[n]  = ext_reg[n] && (thr_reg[n].count == '0 || device_reset_event ||
                                         lli_fire);

        always_ff @(posedge aclk) begin
            // only the bus reset clears a throttle; software device reset does not reach it
            if (!aresetn) begin
                thr_reg[n] <= '0;
            end else begin
                if (thr_wr) begin
                    thr_reg[n].interval <= m[IATM_INTERVAL_LSB +: IATM_INTERVAL_W];
                    thr_reg[n].low_latency_moderation_enable   <= m[IATM_LOW_LATENCY_MODERATION_ENABLE_POS];
                end
                if (thr_wr && !wdat[IATM_PRESERVE_POS]) begin
                    thr_reg[n].count <= {m[IATM_MODCNT_LSB +: IATM_MODCNT_W], 2'h0};
                end else if (fire[n]) begin
                    // the real counter is 12 bits; longer intervals saturate it
                    thr_reg[n].count <= (thr_reg[n].interval > 13'(IATM_COUNT_MAX)) ?
                                        IATM_COUNT_MAX : thr_reg[n].interval[IATM_COUNT_W-1:0];
                end else if (tick_reg && thr_reg[n].count != '0) begin
                    thr_reg[n].count <= thr_reg[n].count - 1'b1;
                end
                if (thr_wr && !wdat[IATM_PRESERVE_POS]) begin
                    thr_reg[n].credit <= m[IATM_CREDIT_LSB +: IATM_CREDIT_W];
                end else if (fire[n] && lli_fire) begin
                    thr_reg[n].credit <= thr_reg[n].credit - 1'b1;
                end else if (ll_tick_reg && thr_reg[n].credit != IATM_CREDIT_MAX) begin
                    thr_reg[n].credit <= thr_reg[n].credit + 1'b1;
                end
            end
        end
    end
endmodule : iatm_top
`default_nettype wire

// >>> iatm_chk_sva.sv
// iatm_chk_sva: port assertions for the interrupt auto-mask / throttle / map block
`timescale 1ns/1ns
`default_nettype none
module iatm_chk
    import iatm_pkg::*;
(
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic [IATM_ADDR_W-1:0]  s_axi_araddr,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic                    device_reset_event,
    input wire logic [IATM_NUM_THR-1:0] vector_irq,
    input wire logic [IATM_NUM_THR-1:0] extended_cause_reg
);
    // arready is low while rvalid stands, so this holds the address of the shown data
    logic [IATM_ADDR_W-1:0] rd_addr_reg;
    always_ff @(posedge aclk) if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    thr_rsvd_a: assert property (s_axi_rvalid && rd_addr_reg[15:5] == 11'h0B4
        |-> (s_axi_rdata & 32'h8000_0003) == 32'h0) else $error("throttle reserved bits set");
    alloc_rsvd_a: assert property (s_axi_rvalid && rd_addr_reg[15:3] == 13'h02E0
        |-> (s_axi_rdata & 32'h7878_7878) == 32'h0) else $error("alloc reserved bits set");
    am_rsvd_a: assert property (s_axi_rvalid && rd_addr_reg == IATM_AUTO_MASK_OFF
        |-> !s_axi_rdata[31]) else $error("auto-mask bit 31 set");
    fire_cause_a: assert property (vector_irq != 5'h00
        |-> (vector_irq & ~$past(extended_cause_reg)) == 5'h00) else $error("irq without cause");
    flush_a: assert property (device_reset_event |=>
        (vector_irq & $past(extended_cause_reg)) == $past(extended_cause_reg)) else $error("no flush");
    gap_a: assert property ((vector_irq & $past(vector_irq)) == 5'h00)
        else $error("back to back vector irq");
    rd_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response stuck");
endmodule : iatm_chk
bind iatm_top iatm_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .device_reset_event(device_reset_event), .vector_irq(vector_irq),
    .extended_cause_reg(extended_cause_reg));
`default_nettype wire

// >>> testbench.sv
// testbench: register-level test of the interrupt auto-mask / throttle / map block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import iatm_pkg::*;
    logic        aclk, awready, wready, bvalid, arready, rvalid, irq;
    logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        swrst = 1'b0, devrst = 1'b0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000, rdata, rdat;
    logic [30:0] cev = 31'h0000_0000;
    logic [7:0]  qcb = 8'h00;
    logic [4:0]  vec, ext;
    logic [1:0]  rresp, rrsp, bresp;
    int          fails = 0, checked = 0, g;
    iatm_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .cause_event(cev), .queue_cause_bits(qcb), .low_latency_event(5'h00),
        .software_device_reset(swrst), .device_reset_event(devrst), .irq_out(irq),
        .vector_irq(vec), .extended_cause_reg(ext));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", nm, e, s);
            fails++;
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
    endtask : wr
    task rc(input logic [15:0] a, input logic [31:0] e);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rdat = rdata;
        rrsp = rresp;
        chk($sformatf("reg %h", a), e, rdat);
    endtask : rc
    task qp(input logic [7:0] b);
        qcb <= b;
        @(posedge aclk);
        qcb <= 8'h00;
    endtask : qp
    // bounded wait, g counts cycles until some throttle unit signals
    task wv;
        g = 0;
        do begin
            @(posedge aclk);
            g++;
        end while (vec === 5'h00 && g < 2000);
    endtask : wv
    task results;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        #100000;
        fails++;
        results();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(IATM_AUTO_MASK_OFF, 32'h0);
        rc(16'h1680, 32'h0);
        rc(16'h0004, 32'h0);
        chk("resp", 32'h3, {30'h0, rrsp});
        wr(16'h0004, 32'h1);
        chk("bresp", 32'h3, {30'h0, bresp});
        wr(IATM_AUTO_MASK_OFF, 32'hFFFF_FFFF);
        rc(IATM_AUTO_MASK_OFF, 32'h7FFF_FFFF);
        swrst <= 1'b1;
        @(posedge aclk);
        swrst <= 1'b0;
        rc(IATM_AUTO_MASK_OFF, 32'h4000_0000);
        wr(16'h1680, 32'h001A_800B);
        rc(16'h1680, 32'h001A_8008);
        wr(16'h1680, 32'h8000_001C);
        rc(16'h1680, 32'h001A_001C);
        for (int n = 1; n < 5; n++) begin
            wr(16'h1680 + 16'(4 * n), 32'(n + 1) << 2);
            rc(16'h1680 + 16'(4 * n), 32'(n + 1) << 2);
        end
        wr(16'h1700, 32'hFBFB_FBFB);
        rc(16'h1700, 32'h8383_8383);
        wr(16'h1700, 32'h8382_8180);
        qp(8'h04);
        wv();
        chk("route", 32'h4, {27'h0, vec});
        qp(8'h04);
        @(posedge aclk);
        chk("ext pend", 32'h4, {27'h0, ext});
        wv();
        // the shared tick makes the first microsecond partial, hence the slack
        chk("gap", 32'h1, {31'h0, g >= 495 && g <= 760});
        qp(8'h04);
        devrst <= 1'b1;
        @(posedge aclk);
        devrst <= 1'b0;
        wv();
        chk("flush", 32'h1, {31'h0, g <= 3});
        wr(IATM_CONTROL_OFF, 32'h10);
        wr(16'h1704, 32'h84);
        qp(8'h10);
        wv();
        chk("vector", 32'h10, {27'h0, vec});
        wr(IATM_MASK_SET_OFF, 32'h20);
        cev <= 31'h20;
        @(posedge aclk);
        cev <= 31'h0;
        repeat (2) @(posedge aclk);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(IATM_MASK_CLR_OFF, 32'h0);
        rc(IATM_MASK_SET_OFF, 32'h20);
        chk("irq kept", 32'h1, {31'h0, irq});
        wr(IATM_AUTO_MASK_OFF, 32'h20);
        rc(IATM_CAUSE_OFF, 32'hC000_0020);
        rc(IATM_MASK_CLR_OFF, 32'h0);
        chk("irq off", 32'h0, {31'h0, irq});
        results();
    end
endmodule : testbench
`default_nettype wire
